/* File: rtl/burst_sram_pkg.sv */
// Constants and types for the burst-of-four synchronous SRAM port model
package burst_sram_pkg;
   // Data width and number of write select lanes
   localparam int DATA_W = 18;
   localparam int LANE_W = 2;
   localparam int ADDR_W = 6;
   localparam int BURST_LEN = 4;
   // Low lane width: 4 for nibble parts, 9 for byte parts
   localparam int LOW_LANE_W = (DATA_W == 8) ? 4 : 9;
   // Reset values
   localparam logic [DATA_W-1:0] READ_DATA_RST = {DATA_W{1'b0}};
   localparam logic [1:0] BEAT_RST = 2'h0;
   // Sequencer states, one-hot
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_LAST_READ = 3'h2,
      ST_LAST_WRITE = 3'h4
   } last_op_e;
endpackage

/* File: rtl/burst_lane_merge.sv */
// Merge of one write beat into a stored word under lane selects
`timescale 1ns/1ps
module burst_lane_merge
   import burst_sram_pkg::*;
(
   // Old stored word and new beat
   input wire logic [DATA_W-1:0] oldWord,
   input wire logic [DATA_W-1:0] newWord,
   // Active-low lane selects for this beat
   input wire logic [LANE_W-1:0] laneSel_n,
   // Merged result
   output logic [DATA_W-1:0] mergedWord
);
   always_comb begin
      mergedWord = oldWord;
      if (LANE_W == 1) begin
         if (!laneSel_n[0]) begin
            mergedWord = newWord;
         end
      end else begin
         // low lane gated by select 0
         if (!laneSel_n[0]) begin
            mergedWord[LOW_LANE_W-1:0] = newWord[LOW_LANE_W-1:0];
         end
         // high lane gated by select 1
         if (!laneSel_n[LANE_W-1]) begin
            mergedWord[DATA_W-1:LOW_LANE_W] = newWord[DATA_W-1:LOW_LANE_W];
         end
      end
      // all selects high leaves oldWord untouched
   end
endmodule

/* File: rtl/burst_sram_port.sv */
// Burst-of-four SRAM: command sequencing, write merge and read burst out
`timescale 1ns/1ps
module burst_sram_port
   import burst_sram_pkg::*;
(
   // Clock and reset (ref_clk rise = input clock rise; DDR beats become one-clock beats)
   input wire logic ref_clk,
   input wire logic rst_n,
   // Command
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   input wire logic [ADDR_W-1:0] addr,
   // Write data, one beat per clock
   input wire logic [DATA_W-1:0] writeData,
   input wire logic [LANE_W-1:0] byte_write_select_n,
   // Read data, pad drive
   output logic [DATA_W-1:0] readData,
   output logic readDataOe_n,
   output logic readValid
);
   // ****************************************
   // Storage and sequencing state
   // ****************************************
   // edge-held state, frozen while clock stops
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Array
   last_op_e lastOp_r; // Previous start kind
   logic wrActive_r; // Write burst in flight
   logic [1:0] wrBeat_r; // Write beat index
   logic [ADDR_W-1:0] wrAddr_r; // Latched write address
   logic rdActive_r; // Read burst in flight
   logic [1:0] rdBeat_r; // Read beat index
   logic [ADDR_W-1:0] rdAddr_r; // Latched read address
   logic startRead; // Read accepted this edge
   logic startWrite; // Write accepted this edge
   logic [DATA_W-1:0] merged; // Beat merged with old word
   logic wrBeatNow; // Write beat sampled this edge
   logic [ADDR_W-1:0] wrLoc; // Location of this write beat

   // Burst address: base plus beat, linear, wrapping only at the top of the array
   function automatic logic [ADDR_W-1:0] beatAddr(input logic [ADDR_W-1:0] base, input logic [1:0] beat);
      beatAddr = base + {{(ADDR_W-2){1'b0}}, beat};
   endfunction

   // ****************************************
   // Start decode and arbitration
   // ****************************************
   always_comb begin
      startRead = 1'b0;
      startWrite = 1'b0;
      // no same-kind start twice in a row; read first
      if (!read_port_select_n && lastOp_r != ST_LAST_READ && !rdActive_r) begin
         startRead = 1'b1;
      end else if (!write_port_select_n && lastOp_r != ST_LAST_WRITE && !wrActive_r) begin
         startWrite = 1'b1;
      end
   end

   // Previous start tracker
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         lastOp_r <= ST_IDLE;
      end else begin
         case (lastOp_r)
            ST_IDLE, ST_LAST_READ, ST_LAST_WRITE: begin
               if (startRead) begin
                  lastOp_r <= ST_LAST_READ;
               end else if (startWrite) begin
                  lastOp_r <= ST_LAST_WRITE;
               end else begin
                  lastOp_r <= ST_IDLE;
               end
            end
            default: begin
               lastOp_r <= ST_IDLE;
            end
         endcase
      end
   end

   // ****************************************
   // Write path
   // ****************************************
   // Beats run back to back from the edge after the start
   assign wrBeatNow = wrActive_r;
   assign wrLoc = beatAddr(wrAddr_r, wrBeat_r);

   burst_lane_merge u_merge (
      .oldWord(mem[wrLoc]),
      .newWord(writeData),
      .laneSel_n(byte_write_select_n),
      .mergedWord(merged)
   );

   // Write burst control
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrActive_r <= 1'b0;
         wrBeat_r <= BEAT_RST;
         wrAddr_r <= '0;
      end else if (startWrite) begin
         // latch address; beats follow next edge
         wrActive_r <= 1'b1;
         wrBeat_r <= BEAT_RST;
         wrAddr_r <= addr;
      end else if (wrBeatNow) begin
         wrBeat_r <= wrBeat_r + 2'h1;
         if (wrBeat_r == 2'h3) begin
            wrActive_r <= 1'b0;
         end
      end
   end

   // Array store, one beat per edge
   always_ff @(posedge ref_clk) begin
      // each beat and its selects sampled on its own edge
      if (wrBeatNow) begin
         mem[wrLoc] <= merged;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // Read burst control: first word one edge after the start edge
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdActive_r <= 1'b0;
         rdBeat_r <= BEAT_RST;
         rdAddr_r <= '0;
      end else if (startRead) begin
         rdActive_r <= 1'b1;
         rdBeat_r <= BEAT_RST;
         rdAddr_r <= addr;
      end else if (rdActive_r) begin
         rdBeat_r <= rdBeat_r + 2'h1;
         if (rdBeat_r == 2'h3) begin
            rdActive_r <= 1'b0;
         end
      end
   end

   // Output register and pad enable
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         readData <= READ_DATA_RST;
         readDataOe_n <= 1'b1;
         readValid <= 1'b0;
      end else if (rdActive_r) begin
         // words in burst order, one per beat
         readData <= mem[beatAddr(rdAddr_r, rdBeat_r)];
         readDataOe_n <= 1'b0;
         readValid <= 1'b1;
      end else begin
         readDataOe_n <= 1'b1;
         readValid <= 1'b0;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   sequence s_readStart;
      !read_port_select_n && lastOp_r != ST_LAST_READ && !rdActive_r;
   endsequence

   property p_readBurst;
      @(posedge ref_clk) disable iff (!rst_n)
      s_readStart |=> ##1 readValid [*4];
   endproperty
   a_readBurst: assert property (p_readBurst) else $error("read burst not four beats");

   property p_noBackRead;
      @(posedge ref_clk) disable iff (!rst_n)
      startRead |=> !startRead;
   endproperty
   a_noBackRead: assert property (p_noBackRead) else $error("back to back read accepted");

   property p_noBackWrite;
      @(posedge ref_clk) disable iff (!rst_n)
      startWrite |=> !startWrite;
   endproperty
   a_noBackWrite: assert property (p_noBackWrite) else $error("back to back write accepted");

   property p_readFirst;
      @(posedge ref_clk) disable iff (!rst_n)
      (lastOp_r == ST_IDLE && !rdActive_r && !read_port_select_n && !write_port_select_n) |-> startRead;
   endproperty
   a_readFirst: assert property (p_readFirst) else $error("read lost priority from idle");

   property p_nop;
      @(posedge ref_clk) disable iff (!rst_n)
      (read_port_select_n && write_port_select_n) |-> !startRead && !startWrite;
   endproperty
   a_nop: assert property (p_nop) else $error("operation started while deselected");

   property p_oeTracksValid;
      @(posedge ref_clk) disable iff (!rst_n)
      readDataOe_n == !readValid;
   endproperty
   a_oeTracksValid: assert property (p_oeTracksValid) else $error("pad enable disagrees with valid");

   // Four write beats on consecutive edges
   sequence s_writeFourBeats;
      wrBeatNow [*4];
   endsequence

   property p_writeBeats;
      @(posedge ref_clk) disable iff (!rst_n)
      startWrite |=> s_writeFourBeats ##1 !wrActive_r;
   endproperty
   a_writeBeats: assert property (p_writeBeats) else $error("write burst not four beats");

   property p_writeAddr;
      @(posedge ref_clk) disable iff (!rst_n)
      startWrite |=> ##3 (wrLoc == beatAddr($past(addr, 4), 2'h3));
   endproperty
   a_writeAddr: assert property (p_writeAddr) else $error("write burst address wrong");

   // Write takes its turn right after a read start
   property p_writeAfterRead;
      @(posedge ref_clk) disable iff (!rst_n)
      (lastOp_r == ST_LAST_READ && !write_port_select_n && !wrActive_r) |-> startWrite;
   endproperty
   a_writeAfterRead: assert property (p_writeAfterRead) else $error("write lost turn after read");

   // Pads released once no read burst is in flight
   property p_padRelease;
      @(posedge ref_clk) disable iff (!rst_n)
      !rdActive_r |=> readDataOe_n && !readValid;
   endproperty
   a_padRelease: assert property (p_padRelease) else $error("read pads driven with no burst");
endmodule

/* File: tb/burst_ctrl_model.sv */
// Memory controller model driving commands and write beats
`timescale 1ns/1ps
module burst_ctrl_model
   import burst_sram_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Command and write beats
   output logic read_port_select_n,
   output logic write_port_select_n,
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] writeData,
   output logic [LANE_W-1:0] byte_write_select_n
);
   // Single-clock strap: no output clocks, ref_clk times reads
   // Idle levels at time zero
   initial begin
      read_port_select_n = 1'b1;
      write_port_select_n = 1'b1;
      addr = '0;
      writeData = '0;
      byte_write_select_n = '1;
   end
   task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [4*DATA_W-1:0] d,
      input logic [4*LANE_W-1:0] s);
      @(negedge ref_clk);
      write_port_select_n = 1'b0;
      addr = a;
      writeData = ~writeData;
      for (int i = 0; i < 4; i++) begin
         @(negedge ref_clk);
         write_port_select_n = 1'b1;
         addr = ~addr;
         writeData = d[i*DATA_W +: DATA_W];
         byte_write_select_n = s[i*LANE_W +: LANE_W];
      end
   endtask
   // Optional second read on the next edge
   task automatic read_start(input logic [ADDR_W-1:0] a, input bit twice);
      @(negedge ref_clk);
      read_port_select_n = 1'b0;
      addr = a;
      if (twice) begin
         @(negedge ref_clk);
         addr = ~a;
      end
      @(negedge ref_clk);
      read_port_select_n = 1'b1;
      addr = ~addr;
   endtask
   // Both selects low from idle: read first, write next edge
   task automatic dual_start(input logic [ADDR_W-1:0] ra, input logic [ADDR_W-1:0] wa,
      input logic [4*DATA_W-1:0] d, input logic [4*LANE_W-1:0] s);
      @(negedge ref_clk);
      read_port_select_n = 1'b0;
      write_port_select_n = 1'b0;
      addr = ra;
      @(negedge ref_clk);
      addr = wa;
      for (int i = 0; i < 4; i++) begin
         @(negedge ref_clk);
         read_port_select_n = 1'b1;
         write_port_select_n = 1'b1;
         addr = ~addr;
         writeData = d[i*DATA_W +: DATA_W];
         byte_write_select_n = s[i*LANE_W +: LANE_W];
      end
   endtask
endmodule

/* File: tb/tb_quad_rate_burst_sram_port.sv */
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
module tb_quad_rate_burst_sram_port;
   import burst_sram_pkg::*;
   // ****************
   // Signals
   // ****************
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic rdSel_n, wrSel_n, readDataOe_n, readValid;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] writeData, readData;
   logic [LANE_W-1:0] laneSel_n;
   logic [DATA_W-1:0] mirror [2**ADDR_W];
   int errors = 0;
   int samples_checked = 0;
   int seed = 47151;
   bit clkRun = 1'b1;
   bit pauseRd = 1'b0;
   // 50 MHz clock, parked low while clkRun is low
   always #10 ref_clk = clkRun ? ~ref_clk : ref_clk;
   burst_ctrl_model ctrl (.ref_clk(ref_clk), .read_port_select_n(rdSel_n), .write_port_select_n(wrSel_n),
      .addr(addr), .writeData(writeData), .byte_write_select_n(laneSel_n));
   burst_sram_port dut (.ref_clk(ref_clk), .rst_n(rst_n), .read_port_select_n(rdSel_n),
      .write_port_select_n(wrSel_n), .addr(addr), .writeData(writeData), .byte_write_select_n(laneSel_n),
      .readData(readData), .readDataOe_n(readDataOe_n), .readValid(readValid));
   // Expected word after one lane-masked beat
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, input logic [DATA_W-1:0] n,
      input logic [LANE_W-1:0] s);
      merge = o;
      if (s[0] == 1'b0) merge[LOW_LANE_W-1:0] = n[LOW_LANE_W-1:0];
      if (s[1] == 1'b0) merge[DATA_W-1:LOW_LANE_W] = n[DATA_W-1:LOW_LANE_W];
   endfunction
   // Compare tasks
   task automatic check_word(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic check_bit(input string nm, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value %s expected %b seen %b", nm, e, g);
      end
   endtask
   // Random burst, mirror updated beat by beat
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [4*LANE_W-1:0] s);
      logic [4*DATA_W-1:0] d;
      logic [ADDR_W-1:0] p;
      for (int i = 0; i < 4; i++) begin
         d[i*DATA_W +: DATA_W] = DATA_W'($random(seed));
         p = a + ADDR_W'(i);
         mirror[p] = merge(mirror[p], d[i*DATA_W +: DATA_W], s[i*LANE_W +: LANE_W]);
      end
      ctrl.write_burst(a, d, s);
   endtask
   // Read burst and four output beats
   task automatic rd(input logic [ADDR_W-1:0] a, input bit twice);
      ctrl.read_start(a, twice);
      // First word stands after the edge that follows the start
      repeat (twice ? 0 : 1) @(negedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         check_bit("readValid", 1'b1, readValid);
         check_bit("readDataOe_n", 1'b0, readDataOe_n);
         check_word("readData", mirror[a+ADDR_W'(i)], readData);
         if (pauseRd && i == 1) begin
            // clock parked low mid-burst, restarted half a period out of phase
            clkRun = 1'b0;
            #195;
            check_word("readData held", mirror[a+ADDR_W'(i)], readData);
            check_bit("readValid held", 1'b1, readValid);
            clkRun = 1'b1;
         end
         @(negedge ref_clk);
      end
      check_bit("readValid end", 1'b0, readValid);
      check_bit("readDataOe_n end", 1'b1, readDataOe_n);
   endtask
   // Read and write selected together from idle
   task automatic dual(input logic [ADDR_W-1:0] ra, input logic [ADDR_W-1:0] wa);
      logic [4*DATA_W-1:0] d;
      logic [ADDR_W-1:0] p;
      for (int i = 0; i < 4; i++) begin
         d[i*DATA_W +: DATA_W] = DATA_W'($random(seed));
         p = wa + ADDR_W'(i);
         mirror[p] = merge(mirror[p], d[i*DATA_W +: DATA_W], {LANE_W{1'b0}});
      end
      fork
         ctrl.dual_start(ra, wa, d, {(4*LANE_W){1'b0}});
         begin
            repeat (3) @(negedge ref_clk);
            for (int i = 0; i < 4; i++) begin
               check_word("dual readData", mirror[ra+ADDR_W'(i)], readData);
               @(negedge ref_clk);
            end
            check_bit("dual readValid end", 1'b0, readValid);
         end
      join
   endtask
   // Verdict
   task automatic final_report();
      if (errors == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Watchdog
   initial begin
      #1ms;
      errors++;
      final_report();
   end
   // Main sequence
   initial begin
      repeat (12) @(negedge ref_clk);
      check_bit("reset oe", 1'b1, readDataOe_n);
      check_bit("reset valid", 1'b0, readValid);
      rst_n = 1'b1;
      for (int a = 0; a < 64; a += 4) wr(ADDR_W'(a), 8'h00);
      wr(6'h3E, 8'hFF);
      wr(6'h3E, 8'h1B);
      wr(6'h10, 8'h99);
      for (int i = 0; i < 40; i++) wr(ADDR_W'($random(seed)), 8'($random(seed)));
      for (int i = 0; i < 5; i++) begin
         @(negedge ref_clk);
         check_bit("idle valid", 1'b0, readValid);
      end
      dual(6'h08, 6'h30);
      rd(6'h30, 1'b0);
      rd(6'h3E, 1'b0);
      pauseRd = 1'b1;
      rd(6'h10, 1'b0);
      pauseRd = 1'b0;
      rd(6'h21, 1'b1);
      for (int i = 0; i < 30; i++) rd(ADDR_W'($random(seed)), 1'b0);
      final_report();
   end
endmodule
